// [ols_pkg.sv]
// Purpose: shared constants and types for the optical link status lamps
// Assumes: 200 MHz system clock, 32-bit AHB-Lite register access
// Notes:   lane rate codes and register offsets are used by the top module
package ols_pkg;
    // lane rate code from the link logic
    localparam logic [1:0] RATE_OFF   = 2'h0;
    localparam logic [1:0] RATE_G1    = 2'h1; // 2.5 GT/s
    localparam logic [1:0] RATE_G2    = 2'h2; // 5.0 GT/s
    // configured width codes
    localparam logic [1:0] WID_X1     = 2'h0;
    localparam logic [1:0] WID_X2     = 2'h1;
    localparam logic [1:0] WID_X4     = 2'h2;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PRESC  = 8'h04;
    localparam logic [7:0] OFS_STAT   = 8'h08;
    localparam logic [7:0] OFS_IRQ_ST = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MK = 8'h10;
    // ctrl fields
    localparam int CTRL_PWR   = 0;
    localparam int CTRL_WID_L = 1;
    // interrupt status bits
    localparam int IRQ_FATAL  = 0;
    localparam int IRQ_LOS    = 1;
    localparam int IRQ_FAIL   = 2;
    localparam int IRQ_LINK   = 3;
    localparam int IRQ_W      = 4;
    // blink timing
    localparam int BLINK_HALF_MS  = 500;
    localparam int CLK_MHZ        = 200;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
    localparam int CNT_W          = 27;
    // operating mode
    typedef enum logic {MODE_HOST, MODE_REMOTE} ols_mode_t;
    // lane rates from the link logic
    typedef struct packed {
        logic [3:0][1:0] loc_rate;
        logic [3:0][1:0] opt_rate;
    } ols_lanes_t;
    // indicator bundle
    typedef struct packed {
        logic [3:0] loc;
        logic [3:0] opt;
        logic [3:0] fail;
        logic [3:0] xcvr;
        logic [3:0] los;
        logic       fatal;
    } ols_lamps_t;
    // whole module state
    typedef struct packed {
        logic [1:0]       mode_s;   // switch sync chain
        logic [3:0]       pres_s1;
        logic [3:0]       pres_s2;
        logic [3:0]       los_s1;
        logic [3:0]       los_s2;
        logic [CNT_W-1:0] cnt;
        logic             phase;
        ols_lamps_t       lamps;
        logic [3:0]       fail_p;
        logic             link_p;
        logic             pwr_on;
        logic [1:0]       wid;
        logic [CNT_W-1:0] presc;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mk;
        logic             irq;
        logic             wr_pend;
        logic [7:0]       wr_ofs;
        logic [31:0]      rdata;
        logic             sup_o;
        logic             sup_oe;
        logic             rok_o;
        logic             rok_oe;
    } ols_state_t;
endpackage

// [ols_status_leds.sv]
// Purpose: status lamps, sideband pin control and AHB-Lite registers
// Assumes: lane rates and fatal/reset levels come from this clock domain
// Notes:   switch, transceiver present and loss pins are synchronised
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ols_status_leds
    import ols_pkg::*;
#(
    parameter logic [CNT_W-1:0] BLINK_HALF = CNT_W'(BLINK_HALF_CYC)
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // status sources
    input  wire ols_lanes_t  i_lanes,
    input  wire logic        i_fatal_err,
    input  wire logic        i_resets_released,
    input  wire logic        i_mode_select_switch,
    input  wire logic [3:0]  i_xcvr_present,
    input  wire logic [3:0]  i_xcvr_los,
    input  wire logic        i_power_switch_n,
    input  wire logic        i_manual_reset_n,
    // lamps
    output ols_lamps_t       o_lamps,
    output logic             o_link_ok,
    output logic             o_irq,
    // sideband pins
    output logic             o_supply_en_o,
    output logic             o_supply_en_oe,
    output logic             o_resets_released_lamp_n_o,
    output logic             o_resets_released_lamp_n_oe
);
    ols_state_t s_q;      // registered state
    ols_state_t s_d;      // next state
    ols_mode_t  mode;     // synchronised mode
    logic [3:0] act;      // optical lane active
    logic [2:0] n_pres;   // installed fibre count
    logic [2:0] n_need;   // count demanded by width
    logic       link_ok;  // fibre count matches width
    logic       ahb_go;   // valid address phase
    logic [IRQ_W-1:0] ev; // interrupt events this cycle
    logic [IRQ_W-1:0] clr;

    // lamp from rate code and blink phase
    function automatic logic lamp_of(input logic [1:0] r,
                                     input logic ph);
        lamp_of = (r == RATE_G2) | ((r == RATE_G1) & ph);
    endfunction

    // width code to required fibre count
    function automatic logic [2:0] need_of(input logic [1:0] w);
        if (w == WID_X1) begin
            need_of = 3'h1;
        end else if (w == WID_X2) begin
            need_of = 3'h2;
        end else begin
            need_of = 3'h4;
        end
    endfunction

    // register read mux, reserved bits zero
    function automatic logic [31:0] rd_of(input ols_state_t s,
                                          input logic [7:0] a,
                                          input logic lk);
        if (a == OFS_CTRL) begin
            rd_of = {29'h0000_0000, s.wid, s.pwr_on};
        end else if (a == OFS_PRESC) begin
            rd_of = 32'(s.presc);
        end else if (a == OFS_STAT) begin
            rd_of = {22'h00_0000, s.lamps.fatal, lk, s.los_s2,
                     s.pres_s2};
        end else if (a == OFS_IRQ_ST) begin
            rd_of = 32'(s.irq_st);
        end else if (a == OFS_IRQ_MK) begin
            rd_of = 32'(s.irq_mk);
        end else begin
            rd_of = 32'h0000_0000;
        end
    endfunction

    // decoded view of the synchronised pins
    always_comb begin
        mode    = s_q.mode_s[1] ? MODE_REMOTE : MODE_HOST;
        n_pres  = 3'h0;
        for (int i = 0; i < 4; i++) begin
            n_pres = n_pres + {2'h0, s_q.pres_s2[i]};
        end
        n_need  = need_of(s_q.wid);
        // a match needs the right count and port n_need-1 installed
        link_ok = (n_pres == n_need) &
                  (s_q.pres_s2[32'(n_need) - 1]);
        for (int i = 0; i < 4; i++) begin
            act[i] = (i_lanes.opt_rate[i] != RATE_OFF);
        end
        ahb_go  = hsel & hready & htrans[1];
    end

    // next state
    always_comb begin
        s_d = s_q;
        // two-stage synchronisers for pins
        s_d.mode_s  = {s_q.mode_s[0], i_mode_select_switch};
        s_d.pres_s1 = i_xcvr_present;
        s_d.pres_s2 = s_q.pres_s1;
        s_d.los_s1  = i_xcvr_los;
        s_d.los_s2  = s_q.los_s1;
        // shared blink prescaler, one phase for all lamps
        if (s_q.cnt >= s_q.presc - CNT_W'(1)) begin
            s_d.cnt   = '0;
            s_d.phase = ~s_q.phase;
        end else begin
            s_d.cnt   = s_q.cnt + CNT_W'(1);
        end
        // lamps
        for (int i = 0; i < 4; i++) begin
            s_d.lamps.loc[i]  = lamp_of(i_lanes.loc_rate[i],
                                        s_q.phase);
            // optical lamps of lanes beyond the configured width stay dark
            s_d.lamps.opt[i]  = lamp_of(i_lanes.opt_rate[i],
                                s_q.phase) &
                                (3'(i) < n_need);
            s_d.lamps.xcvr[i] = lamp_of(i_lanes.opt_rate[i],
                                s_q.phase) & s_q.pres_s2[i];
            s_d.lamps.fail[i] = s_q.pres_s2[i] & ~act[i];
            s_d.lamps.los[i]  = s_q.los_s2[i];
        end
        s_d.lamps.fatal = s_q.lamps.fatal | i_fatal_err;
        // events for the interrupt status
        ev            = '0;
        ev[IRQ_FATAL] = i_fatal_err & ~s_q.lamps.fatal;
        ev[IRQ_LOS]   = |(s_q.los_s2 & ~s_q.lamps.los);
        ev[IRQ_FAIL]  = |(s_d.lamps.fail & ~s_q.fail_p);
        ev[IRQ_LINK]  = link_ok ^ s_q.link_p;
        s_d.fail_p    = s_d.lamps.fail;
        s_d.link_p    = link_ok;
        // bus write in data phase
        clr = '0;
        if (s_q.wr_pend) begin
            if (s_q.wr_ofs == OFS_CTRL) begin
                s_d.pwr_on = hwdata[CTRL_PWR];
                s_d.wid    = hwdata[CTRL_WID_L +: 2];
            end else if (s_q.wr_ofs == OFS_PRESC) begin
                // zero would wrap to the longest blink period; clamp to one
                s_d.presc  = (hwdata[CNT_W-1:0] == '0) ?
                             CNT_W'(1) : hwdata[CNT_W-1:0];
            end else if (s_q.wr_ofs == OFS_IRQ_ST) begin
                clr        = hwdata[IRQ_W-1:0];
            end else if (s_q.wr_ofs == OFS_IRQ_MK) begin
                s_d.irq_mk = hwdata[IRQ_W-1:0];
            end
        end
        // a new event beats a clear in the same cycle
        s_d.irq_st = (s_q.irq_st & ~clr) | ev;
        s_d.irq    = |(s_d.irq_st & s_d.irq_mk);
        // address phase capture, zero wait state
        s_d.wr_pend = ahb_go & hwrite;
        s_d.wr_ofs  = haddr[7:0];
        if (ahb_go & ~hwrite) begin
            s_d.rdata = rd_of(s_q, haddr[7:0], link_ok);
        end
        // sideband pins by mode
        if (mode == MODE_REMOTE) begin
            s_d.sup_o  = ~s_q.pwr_on;
            s_d.sup_oe = 1'b1;
            s_d.rok_o  = ~i_resets_released;
            s_d.rok_oe = 1'b1;
        end else begin
            // host: released to the board pull-ups
            s_d.sup_o  = 1'b1;
            s_d.sup_oe = 1'b0;
            s_d.rok_o  = 1'b1;
            s_d.rok_oe = 1'b0;
        end
    end

    // power switch and manual reset inputs are only meaningful in remote mode
    // and are consumed by the sequencing logic outside; here
    // they are deliberately left unread in both modes

    // state register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q        <= '0;
            s_q.presc  <= BLINK_HALF;
            s_q.sup_o  <= 1'b1;
            s_q.rok_o  <= 1'b1;
        end else begin
            s_q        <= s_d;
        end
    end

    // bus response flops
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // outputs straight from flops
    assign hrdata  = s_q.rdata;
    assign o_lamps = s_q.lamps;
    assign o_irq   = s_q.irq;
    assign o_link_ok                   = s_q.link_p;
    assign o_supply_en_o               = s_q.sup_o;
    assign o_supply_en_oe              = s_q.sup_oe;
    assign o_resets_released_lamp_n_o  = s_q.rok_o;
    assign o_resets_released_lamp_n_oe = s_q.rok_oe;

    // blink phase steps once per prescale period
    sequence s_wrap;
        s_q.cnt == s_q.presc - CNT_W'(1);
    endsequence
    chk_blink_flip: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        s_wrap |=> (s_q.phase != $past(s_q.phase)))
        else $error("blink phase did not toggle");
    chk_blink_hold: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        !(s_q.cnt >= s_q.presc - CNT_W'(1)) |=> $stable(s_q.phase))
        else $error("blink phase moved early");
    chk_loc_steady: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (i_lanes.loc_rate[0] == RATE_G2) |=> o_lamps.loc[0])
        else $error("gen2 local lamp not lit");
    chk_loc_off: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (i_lanes.loc_rate[1] == RATE_OFF) |=> !o_lamps.loc[1])
        else $error("inactive local lamp lit");
    chk_opt_blink: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (i_lanes.opt_rate[0] == RATE_G1) |=>
        (o_lamps.opt[0] == $past(s_q.phase)))
        else $error("gen1 optical lamp off phase");
    chk_xcvr_gate: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        !s_q.pres_s2[2] |=> !o_lamps.xcvr[2])
        else $error("xcvr lamp lit without module");
    chk_fail_lamp: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (s_q.pres_s2[1] && !act[1]) |=> o_lamps.fail[1])
        else $error("failure lamp not lit");
    chk_los_path: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        i_xcvr_los[3] ##1 i_xcvr_los[3] |=> ##1 o_lamps.los[3])
        else $error("loss lamp late");
    chk_fatal_stick: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        o_lamps.fatal |=> o_lamps.fatal)
        else $error("fatal lamp dropped");
    chk_host_tri: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (mode == MODE_HOST) |=>
        (!o_supply_en_oe && !o_resets_released_lamp_n_oe))
        else $error("host sideband driven");
    chk_supply_pol: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (mode == MODE_REMOTE) |=> (o_supply_en_o == !$past(s_q.pwr_on)))
        else $error("supply enable polarity");
    chk_rok_pol: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (mode == MODE_REMOTE && i_resets_released) |=>
        !o_resets_released_lamp_n_o)
        else $error("resets lamp not asserted");
    chk_link_match: assert property (@(posedge i_clk)
        disable iff (i_sys_rst)
        (s_q.wid == WID_X4 && s_q.pres_s2 != 4'hf) |-> !link_ok)
        else $error("link up with missing fibre");
endmodule // ols_status_leds

// [ols_board_model.sv]
// Purpose: board side of the adapter: pulled-up sideband wires, switches
// Assumes: released sideband lines float to their pull-up level
// Notes:   a pressed switch pulls its pin low, otherwise the pull-up wins
`timescale 1ns/1ps
module ols_board_model (
    // sideband outputs of the adapter
    input  wire logic i_sup_o,
    input  wire logic i_sup_oe,
    input  wire logic i_rok_o,
    input  wire logic i_rok_oe,
    // momentary switches on the board
    input  wire logic i_press,
    input  wire logic i_mrst,
    // wire levels on the board
    output logic      o_sup_pin,
    output logic      o_rok_pin,
    output logic      o_power_switch_n,
    output logic      o_manual_reset_n
);
    // tri-stated outputs read as the pull-up, never as a stale value
    assign o_sup_pin        = i_sup_oe ? i_sup_o : 1'b1;
    assign o_rok_pin        = i_rok_oe ? i_rok_o : 1'b1;
    // weak pull-up inputs only go low while a switch is held
    assign o_power_switch_n = ~i_press;
    assign o_manual_reset_n = ~i_mrst;
endmodule // ols_board_model

// [optical_link_status_leds_test.sv]
// Purpose: self-checking bench for the status lamp block
// Assumes: short blink half period, slave answers with no wait state
// Notes:   random lane rates from a fixed seed beside hand-picked corners
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module optical_link_status_leds_test;
    import ols_pkg::*;
    localparam int HALF = 8;            // blink half period in cycles
    logic        i_clk = 0;             // 200 MHz clock
    logic        i_sys_rst = 1;         // async reset
    logic        hsel = 0, hwrite = 0;  // bus request
    logic [1:0]  htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
    logic        hreadyout, hresp, o_link_ok, o_irq;
    wire logic   hready = hreadyout;    // single slave drives hready
    ols_lanes_t  lanes = '0;            // lane rate codes
    ols_lamps_t  o_lamps;
    logic        fatal = 0, rel = 0, mode = 0, press = 0, mrst = 0;
    logic [3:0]  pres = '0, los = '0, m;
    logic        sup_o, sup_oe, rok_o, rok_oe, sup_pin, rok_pin, psw_n, mr_n;
    int          err_count = 0, n_tests = 0, c, bad;
    // clock
    always #2.5 i_clk = ~i_clk;
    // device under test with a short prescaler
    ols_status_leds #(.BLINK_HALF(CNT_W'(HALF))) u_ols_status_leds (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .i_lanes(lanes), .i_fatal_err(fatal),
        .i_resets_released(rel), .i_mode_select_switch(mode),
        .i_xcvr_present(pres), .i_xcvr_los(los), .i_power_switch_n(psw_n),
        .i_manual_reset_n(mr_n), .o_lamps(o_lamps), .o_link_ok(o_link_ok),
        .o_irq(o_irq), .o_supply_en_o(sup_o), .o_supply_en_oe(sup_oe),
        .o_resets_released_lamp_n_o(rok_o),
        .o_resets_released_lamp_n_oe(rok_oe));
    // board wiring and switches
    ols_board_model u_ols_board_model (
        .i_sup_o(sup_o), .i_sup_oe(sup_oe), .i_rok_o(rok_o),
        .i_rok_oe(rok_oe), .i_press(press), .i_mrst(mrst),
        .o_sup_pin(sup_pin), .o_rok_pin(rok_pin),
        .o_power_switch_n(psw_n), .o_manual_reset_n(mr_n));
    // steady lamp expected from a rate code
    function automatic logic lit(input logic [1:0] r);
        return r == RATE_G2;
    endfunction
    // one whole-word transfer; holds each phase until hready is seen
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] q);
        @(posedge i_clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
        do @(posedge i_clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // cycles a lamp is lit over n edges, plus lane-to-lane phase slips
    task automatic count_lit(input int n);
        c = 0; bad = 0;
        repeat (n) begin
            @(posedge i_clk);
            c += o_lamps.loc[0];
            if (o_lamps.opt[0] !== o_lamps.loc[0]) bad++;
        end
    endtask
    // verdict
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog: whole run is a few hundred cycles
    initial begin
        #200us;
        err_count++;
        print_verdict();
    end
    // main sequence
    initial begin
        void'($urandom(59));
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        `CHK("lamps", 21'h0, o_lamps)
        `CHK("sup_o", 1'b1, sup_o)
        `CHK("sup_oe", 1'b0, sup_oe)
        $display("test reset done");
        // width x4, steady lanes random, lane 0 blinking
        bus(1, OFS_CTRL, 32'h0000_0004, rd);
        pres <= 4'hf;
        for (int k = 0; k < 6; k++) begin
            m = 4'($urandom) & 4'he;
            for (int i = 0; i < 4; i++) begin
                lanes.loc_rate[i] <= i == 0 ? RATE_G1 : {m[i], 1'b0};
                lanes.opt_rate[i] <= i == 0 ? RATE_G1 : {m[i], 1'b0};
            end
            los <= 4'($urandom);
            repeat (5) @(posedge i_clk);
            for (int i = 1; i < 4; i++) begin
                `CHK("loc", lit(lanes.loc_rate[i]), o_lamps.loc[i])
                `CHK("opt", lit(lanes.opt_rate[i]), o_lamps.opt[i])
            end
            `CHK("los", los, o_lamps.los)
            pres <= 4'($urandom);
            repeat (5) @(posedge i_clk);
            `CHK("xcvr", m & pres, o_lamps.xcvr & 4'he)
            `CHK("fail", ~m & pres & 4'he, o_lamps.fail & 4'he)
        end
        $display("test lane states done");
        count_lit(2 * HALF);
        `CHK("blink", HALF, c)
        `CHK("phase", 0, bad)
        bus(1, OFS_PRESC, 32'h0000_0003, rd);
        repeat (10) @(posedge i_clk);
        count_lit(6);
        `CHK("presc", 3, c)
        $display("test blink done");
        // fatal lamp is sticky, interrupt raised, masked, cleared
        fatal <= 1'b1;
        @(posedge i_clk);
        fatal <= 1'b0;
        // clear the other events but keep the fatal status pending
        bus(1, OFS_IRQ_ST, 32'h0000_000e, rd);
        repeat (3) @(posedge i_clk);
        `CHK("fatal", 1'b1, o_lamps.fatal)
        `CHK("irq_off", 1'b0, o_irq)
        bus(1, OFS_IRQ_MK, 32'h0000_0001, rd);
        repeat (2) @(posedge i_clk);
        `CHK("irq_on", 1'b1, o_irq)
        bus(1, OFS_IRQ_ST, 32'h0000_0001, rd);
        repeat (2) @(posedge i_clk);
        `CHK("irq_clr", 1'b0, o_irq)
        `CHK("fatal_held", 1'b1, o_lamps.fatal)
        $display("test fatal done");
        // link ok only with the fibre count of each width
        for (int w = 0; w < 3; w++) begin
            bus(1, OFS_CTRL, 32'(w << 1), rd);
            pres <= 4'((1 << (1 << w)) - 1);
            repeat (6) @(posedge i_clk);
            `CHK("link", 1'b1, o_link_ok)
            bus(0, OFS_STAT, 32'h0, rd);
            `CHK("stat_link", 1'b1, rd[8])
            pres <= 4'((1 << (1 << w)) - 2);
            repeat (6) @(posedge i_clk);
            `CHK("no_link", 1'b0, o_link_ok)
        end
        bus(0, 8'h20, 32'h0, rd);
        `CHK("unmapped", 33'h0_0000_0000, {hresp, rd})
        $display("test width done");
        // host mode: sideband released, switch inputs have no effect
        for (int k = 0; k < 8; k++) begin
            press <= 1'($urandom);
            mrst <= 1'($urandom);
            rel <= 1'($urandom);
            repeat (3) @(posedge i_clk);
            `CHK("host_sup", 1'b1, sup_pin)
            `CHK("host_rok", 1'b1, rok_pin)
            `CHK("host_oe", 2'b00, {sup_oe, rok_oe})
        end
        // remote mode: supply starts off, then on; resets lamp low
        press <= 1'b0; mrst <= 1'b0; rel <= 1'b0; mode <= 1'b1;
        repeat (5) @(posedge i_clk);
        `CHK("rem_oe", 2'b11, {sup_oe, rok_oe})
        `CHK("sup_off", 1'b1, sup_pin)
        `CHK("rok_off", 1'b1, rok_pin)
        bus(1, OFS_CTRL, 32'h0000_0001, rd);
        rel <= 1'b1;
        repeat (3) @(posedge i_clk);
        `CHK("sup_on", 1'b0, sup_pin)
        `CHK("rok_on", 1'b0, rok_pin)
        $display("test remote done");
        // reset in mid-run clears the lamps, supply back to off
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        `CHK("rst_lamps", 21'h0, o_lamps)
        `CHK("rst_sup", 2'b10, {sup_o, sup_oe})
        `CHK("rst_misc", 2'b00, {o_link_ok, o_irq})
        i_sys_rst <= 1'b0;
        // mode resyncs, supply comes back driven but still off
        repeat (6) @(posedge i_clk);
        `CHK("rst_rem", 2'b11, {sup_o, sup_oe})
        $display("test second reset done");
        print_verdict();
    end
endmodule // optical_link_status_leds_test
